//--- rtl/ltd_logic_transfer_decoder.v
// Logic and data transfer instruction decoder and cycle sequencer.
// Overview of operation
// - AND into accumulator: 5x, 55, 56/57, 54.
// - 52 ANDs A to direct; 53 immediate.
// - OR into accumulator: 4x, 45, 46/47, 44.
// - 42 ORs A to direct; 43 immediate.
// - XOR into accumulator: 6x, 65, 66/67, 64.
// - 62 XORs A to direct; 63 immediate.
// - E4 clears, F4 inverts, C4 swaps nibbles.
// - Rotates 23, 33, 03, 13, one cycle.
// - Loads to accumulator: Ex, E5, E6/E7, 74.
// - Register writes: Fx, Ax two cycles, 7x.
// - Direct writes: F5, 8x, 85, 86/87, 75.
// - Indirect writes: F6/F7, A6/A7, 76/77.
// - 90 loads data pointer, three bytes.
// - Code table reads 93 and 83, two cycles.
// - External reads E2/E3 and E0, two cycles.
// - External writes F2/F3 and F0, two cycles.
// - C0 pushes, D0 pops, two cycles.
// - Byte trades Cx, C5, C6/C7, one cycle.
// - D6/D7 trade low nibbles, one cycle.
// - Low nibble 8-F selects working register 0-7.
// - Low opcode bit picks pointer register 0/1.
// - Direct byte reaches lower RAM or SFRs.
// - Each cycle is twelve oscillator periods.
`include "ltd_consts.vh"
module ltd_logic_transfer_decoder #(
  parameter W = 8,
  parameter OSC_PER_CYC = `LTD_OSC_PER_CYC
) (
  // Clock and reset.
  input wire clk_sys,
  input wire arst_n,
  // Oscillator-rate tick and instruction request.
  input wire oscTick,
  input wire opValid,
  input wire [7:0] opcode,
  // Core state used by accumulator operations.
  input wire [W-1:0] accIn,
  input wire carryIn,
  // Decoded instruction.
  output reg busy_r,
  output reg done_r,
  output reg handled_r,
  output reg [4:0] opKind_r,
  output reg [2:0] srcLoc_r,
  output reg [2:0] dstLoc_r,
  output reg [1:0] length_r,
  output reg [1:0] cycles_r,
  output reg [2:0] regSel_r,
  output reg ptrSel_r,
  output reg [1:0] cycleIdx_r,
  // Accumulator unit results.
  output reg [W-1:0] accOut_r,
  output reg carryOut_r,
  output reg carryWrite_r,
  // Pass-through to other decoders.
  output reg passValid_r,
  output reg [7:0] passOpcode_r
);
  reg [4:0] kind;
  reg [2:0] src;
  reg [2:0] dst;
  reg [1:0] len;
  reg [1:0] cyc;
  reg hit;
  reg [3:0] oscCnt_r;
  reg [3:0] oscCnt_nxt;
  reg cycEnd;
  wire [W-1:0] rotAcc;
  wire rotCarry;
  wire rotCarryWr;
  localparam S_IDLE = 1'b0;
  localparam S_RUN = 1'b1;
  reg state_r;

  function isReg;
    input [7:0] o;
    begin
      isReg = o[3];
    end
  endfunction

  function isInd;
    input [7:0] o;
    begin
      isInd = (o[3:1] == 3'h3);
    end
  endfunction

  // Group decode for the three logic families, which share one layout.
  task logicGroup;
    input [7:0] o;
    input [4:0] k;
    begin
      kind = k;
      dst = `LTD_LOC_ACC;
      len = `LTD_LEN1;
      cyc = `LTD_CYC1;
      hit = 1'b1;
      if (isReg(o)) begin
        src = `LTD_LOC_REG;
      end else if (isInd(o)) begin
        src = `LTD_LOC_IND;
      end else if (o[`LTD_LO] == 4'h5) begin
        src = `LTD_LOC_DIR;
        len = `LTD_LEN2;
      end else if (o[`LTD_LO] == 4'h4) begin
        src = `LTD_LOC_IMM;
        len = `LTD_LEN2;
      end else if (o[`LTD_LO] == 4'h2) begin
        src = `LTD_LOC_ACC;
        dst = `LTD_LOC_DIR;
        len = `LTD_LEN2;
      end else if (o[`LTD_LO] == 4'h3) begin
        src = `LTD_LOC_IMM;
        dst = `LTD_LOC_DIR;
        len = `LTD_LEN3;
        cyc = `LTD_CYC2;
      end else begin
        hit = 1'b0;
        kind = `LTD_OP_NONE;
      end
    end
  endtask

  always @* begin
    kind = `LTD_OP_NONE;
    src = `LTD_LOC_NONE;
    dst = `LTD_LOC_NONE;
    len = `LTD_LEN1;
    cyc = `LTD_CYC1;
    hit = 1'b0;
    case (opcode[`LTD_HI])
      4'h5: logicGroup(opcode, `LTD_OP_AND);
      4'h4: logicGroup(opcode, `LTD_OP_OR);
      4'h6: logicGroup(opcode, `LTD_OP_XOR);
      default: hit = 1'b0;
    endcase
    if (!hit) begin
      hit = 1'b1;
      src = `LTD_LOC_ACC;
      dst = `LTD_LOC_ACC;
      case (opcode)
        8'hE4: kind = `LTD_OP_ZERO;
        8'hF4: kind = `LTD_OP_INV;
        8'hC4: kind = `LTD_OP_NIBSWAP;
        8'h23: kind = `LTD_OP_ROTL;
        8'h33: kind = `LTD_OP_ROTLC;
        8'h03: kind = `LTD_OP_ROTR;
        8'h13: kind = `LTD_OP_ROTRC;
        8'hE5: begin
          kind = `LTD_OP_COPY;
          src = `LTD_LOC_DIR;
          len = `LTD_LEN2;
        end
        8'h74: begin
          kind = `LTD_OP_COPY;
          src = `LTD_LOC_IMM;
          len = `LTD_LEN2;
        end
        8'hF5: begin
          kind = `LTD_OP_COPY;
          dst = `LTD_LOC_DIR;
          len = `LTD_LEN2;
        end
        8'h85: begin
          kind = `LTD_OP_COPY;
          src = `LTD_LOC_DIR;
          dst = `LTD_LOC_DIR;
          len = `LTD_LEN3;
          cyc = `LTD_CYC2;
        end
        8'h75: begin
          kind = `LTD_OP_COPY;
          src = `LTD_LOC_IMM;
          dst = `LTD_LOC_DIR;
          len = `LTD_LEN3;
          cyc = `LTD_CYC2;
        end
        8'h90: begin
          kind = `LTD_OP_DPLOAD;
          src = `LTD_LOC_IMM;
          dst = `LTD_LOC_NONE;
          len = `LTD_LEN3;
          cyc = `LTD_CYC2;
        end
        8'h93, 8'h83: begin
          kind = opcode[4] ? `LTD_OP_CODEDP : `LTD_OP_CODEPC;
          src = `LTD_LOC_CODE;
          cyc = `LTD_CYC2;
        end
        8'hE0, 8'hE2, 8'hE3: begin
          kind = opcode[1] ? `LTD_OP_XRDRI : `LTD_OP_XRDPTR;
          src = `LTD_LOC_XRAM;
          cyc = `LTD_CYC2;
        end
        8'hF0, 8'hF2, 8'hF3: begin
          kind = opcode[1] ? `LTD_OP_XWRRI : `LTD_OP_XWRDPTR;
          dst = `LTD_LOC_XRAM;
          cyc = `LTD_CYC2;
        end
        8'hC0, 8'hD0: begin
          kind = opcode[4] ? `LTD_OP_POP : `LTD_OP_PUSH;
          src = opcode[4] ? `LTD_LOC_NONE : `LTD_LOC_DIR;
          dst = opcode[4] ? `LTD_LOC_DIR : `LTD_LOC_NONE;
          len = `LTD_LEN2;
          cyc = `LTD_CYC2;
        end
        8'hC5: begin
          kind = `LTD_OP_TRADE;
          src = `LTD_LOC_DIR;
          len = `LTD_LEN2;
        end
        8'hC6, 8'hC7: begin
          kind = `LTD_OP_TRADE;
          src = `LTD_LOC_IND;
        end
        8'hD6, 8'hD7: begin
          kind = `LTD_OP_LOWTRADE;
          src = `LTD_LOC_IND;
        end
        default: begin
          hit = 1'b0;
          src = `LTD_LOC_NONE;
          dst = `LTD_LOC_NONE;
        end
      endcase
    end
    if (!hit) begin
      hit = 1'b1;
      case (opcode[`LTD_HI])
        4'hE: begin
          kind = `LTD_OP_COPY;
          dst = `LTD_LOC_ACC;
          src = isReg(opcode) ? `LTD_LOC_REG : `LTD_LOC_IND;
          hit = isReg(opcode) | isInd(opcode);
        end
        4'hF: begin
          kind = `LTD_OP_COPY;
          src = `LTD_LOC_ACC;
          dst = isReg(opcode) ? `LTD_LOC_REG : `LTD_LOC_IND;
          hit = isReg(opcode) | isInd(opcode);
        end
        4'hA: begin
          kind = `LTD_OP_COPY;
          src = `LTD_LOC_DIR;
          dst = isReg(opcode) ? `LTD_LOC_REG : `LTD_LOC_IND;
          len = `LTD_LEN2;
          cyc = `LTD_CYC2;
          hit = isReg(opcode) | isInd(opcode);
        end
        4'h7: begin
          kind = `LTD_OP_COPY;
          src = `LTD_LOC_IMM;
          dst = isReg(opcode) ? `LTD_LOC_REG : `LTD_LOC_IND;
          len = `LTD_LEN2;
          hit = isReg(opcode) | isInd(opcode);
        end
        4'h8: begin
          kind = `LTD_OP_COPY;
          src = isReg(opcode) ? `LTD_LOC_REG : `LTD_LOC_IND;
          dst = `LTD_LOC_DIR;
          len = `LTD_LEN2;
          cyc = `LTD_CYC2;
          hit = isReg(opcode) | isInd(opcode);
        end
        4'hC: begin
          kind = `LTD_OP_TRADE;
          src = `LTD_LOC_REG;
          dst = `LTD_LOC_ACC;
          hit = isReg(opcode);
        end
        default: hit = 1'b0;
      endcase
      if (!hit) begin
        kind = `LTD_OP_NONE;
        src = `LTD_LOC_NONE;
        dst = `LTD_LOC_NONE;
        len = `LTD_LEN1;
        cyc = `LTD_CYC1;
      end
    end
  end

  // Oscillator periods are counted into machine cycles.
  always @* begin
    cycEnd = oscTick && (oscCnt_r == OSC_PER_CYC - 1);
    oscCnt_nxt = oscCnt_r;
    if (state_r == S_IDLE) begin
      oscCnt_nxt = 4'h0;
    end else if (oscTick) begin
      oscCnt_nxt = cycEnd ? 4'h0 : oscCnt_r + 4'h1;
    end
  end

  ltd_rotate_unit #(
    .W(W)
  ) u_rot (
    .op(kind),
    .accIn(accIn),
    .carryIn(carryIn),
    .accOut(rotAcc),
    .carryOut(rotCarry),
    .carryWrite(rotCarryWr)
  );

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
      oscCnt_r <= 4'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      handled_r <= 1'b0;
      opKind_r <= `LTD_OP_NONE;
      srcLoc_r <= `LTD_LOC_NONE;
      dstLoc_r <= `LTD_LOC_NONE;
      length_r <= `LTD_LEN1;
      cycles_r <= `LTD_CYC1;
      regSel_r <= 3'h0;
      ptrSel_r <= 1'b0;
      cycleIdx_r <= 2'h0;
      accOut_r <= {W{1'b0}};
      carryOut_r <= 1'b0;
      carryWrite_r <= 1'b0;
      passValid_r <= 1'b0;
      passOpcode_r <= 8'h00;
    end else begin
      oscCnt_r <= oscCnt_nxt;
      done_r <= 1'b0;
      passValid_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (opValid && hit) begin
            state_r <= S_RUN;
            busy_r <= 1'b1;
            handled_r <= 1'b1;
            opKind_r <= kind;
            srcLoc_r <= src;
            dstLoc_r <= dst;
            length_r <= len;
            cycles_r <= cyc;
            regSel_r <= opcode[`LTD_REGSEL];
            ptrSel_r <= opcode[`LTD_INDSEL];
            cycleIdx_r <= 2'h1;
            accOut_r <= rotAcc;
            carryOut_r <= rotCarry;
            carryWrite_r <= rotCarryWr;
          end else if (opValid) begin
            handled_r <= 1'b0;
            passValid_r <= 1'b1;
            passOpcode_r <= opcode;
          end
        end
        S_RUN: begin
          if (cycEnd) begin
            if (cycleIdx_r == cycles_r) begin
              state_r <= S_IDLE;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              cycleIdx_r <= 2'h0;
            end else begin
              cycleIdx_r <= cycleIdx_r + 2'h1;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

//--- rtl/ltd_consts.vh
// Named constants for the logic and transfer decoder.
`ifndef LTD_CONSTS_VH
`define LTD_CONSTS_VH
// Operation codes.
`define LTD_OP_NONE 5'h00
`define LTD_OP_AND 5'h01
`define LTD_OP_OR 5'h02
`define LTD_OP_XOR 5'h03
`define LTD_OP_ZERO 5'h04
`define LTD_OP_INV 5'h05
`define LTD_OP_NIBSWAP 5'h06
`define LTD_OP_ROTL 5'h07
`define LTD_OP_ROTLC 5'h08
`define LTD_OP_ROTR 5'h09
`define LTD_OP_ROTRC 5'h0A
`define LTD_OP_COPY 5'h0B
`define LTD_OP_DPLOAD 5'h0C
`define LTD_OP_CODEDP 5'h0D
`define LTD_OP_CODEPC 5'h0E
`define LTD_OP_XRDPTR 5'h0F
`define LTD_OP_XRDRI 5'h10
`define LTD_OP_XWRDPTR 5'h11
`define LTD_OP_XWRRI 5'h12
`define LTD_OP_PUSH 5'h13
`define LTD_OP_POP 5'h14
`define LTD_OP_TRADE 5'h15
`define LTD_OP_LOWTRADE 5'h16
// Operand locations.
`define LTD_LOC_NONE 3'h0
`define LTD_LOC_ACC 3'h1
`define LTD_LOC_REG 3'h2
`define LTD_LOC_DIR 3'h3
`define LTD_LOC_IND 3'h4
`define LTD_LOC_IMM 3'h5
`define LTD_LOC_XRAM 3'h6
`define LTD_LOC_CODE 3'h7
// Byte counts and cycle counts.
`define LTD_LEN1 2'h1
`define LTD_LEN2 2'h2
`define LTD_LEN3 2'h3
`define LTD_CYC1 2'h1
`define LTD_CYC2 2'h2
// Oscillator periods in one machine cycle.
`define LTD_OSC_PER_CYC 4'hC
// Accumulator special function register address.
`define LTD_ACC_ADDR 8'hE0
// Opcode fields.
`define LTD_HI 7:4
`define LTD_LO 3:0
`define LTD_REGSEL 2:0
`define LTD_INDSEL 0
`endif

//--- rtl/ltd_rotate_unit.v
// Accumulator rotate, invert, clear and nibble swap unit.
`include "ltd_consts.vh"
module ltd_rotate_unit #(
  parameter W = 8
) (
  // Operands.
  input wire [4:0] op,
  input wire [W-1:0] accIn,
  input wire carryIn,
  // Results.
  output reg [W-1:0] accOut,
  output reg carryOut,
  output reg carryWrite
);
  always @* begin
    accOut = accIn;
    carryOut = carryIn;
    carryWrite = 1'b0;
    case (op)
      `LTD_OP_ZERO: begin
        accOut = {W{1'b0}};
      end
      `LTD_OP_INV: begin
        accOut = ~accIn;
      end
      `LTD_OP_NIBSWAP: begin
        accOut = {accIn[W/2-1:0], accIn[W-1:W/2]};
      end
      `LTD_OP_ROTL: begin
        accOut = {accIn[W-2:0], accIn[W-1]};
      end
      `LTD_OP_ROTR: begin
        accOut = {accIn[0], accIn[W-1:1]};
      end
      `LTD_OP_ROTLC: begin
        accOut = {accIn[W-2:0], carryIn};
        carryOut = accIn[W-1];
        carryWrite = 1'b1;
      end
      `LTD_OP_ROTRC: begin
        accOut = {carryIn, accIn[W-1:1]};
        carryOut = accIn[0];
        carryWrite = 1'b1;
      end
      default: begin
        accOut = accIn;
      end
    endcase
  end
endmodule

//--- verif/ltd_dec_properties.sv
// Timing and decode checks on the decoder's ports.
`include "ltd_consts.vh"
module ltd_dec_properties #(
  parameter int OSC_PER_CYC = 12
) (
  // Clock and reset.
  input wire clk_sys,
  input wire arst_n,
  // Request.
  input wire oscTick,
  input wire opValid,
  input wire [7:0] opcode,
  // Decode.
  input wire busy_r,
  input wire done_r,
  input wire handled_r,
  input wire [4:0] opKind_r,
  input wire [1:0] length_r,
  input wire [1:0] cycles_r,
  input wire [2:0] regSel_r,
  input wire ptrSel_r,
  input wire [1:0] cycleIdx_r,
  input wire carryWrite_r,
  // Pass-through.
  input wire passValid_r,
  input wire [7:0] passOpcode_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busyCnt_r;
  // Counts the ticks of one run; it still holds the total while done_r is up.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) busyCnt_r <= 8'h00;
    else if (!busy_r) busyCnt_r <= 8'h00;
    else if (oscTick) busyCnt_r <= busyCnt_r + 8'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence seq_take;
    !busy_r && opValid;
  endsequence
  sequence seq_run;
    busy_r && $past(busy_r);
  endsequence
  chk_take_answer: assert property (seq_take |=>
    handled_r == busy_r && busy_r != passValid_r) else $error("take");
  chk_pass_copy: assert property (passValid_r |-> !busy_r &&
    passOpcode_r == $past(opcode)) else $error("pass copy");
  chk_pass_pulse: assert property (passValid_r |=> !passValid_r)
    else $error("pass pulse");
  chk_done_pulse: assert property (done_r |=> !done_r)
    else $error("done pulse");
  chk_done_end: assert property (done_r |-> !busy_r &&
    $past(busy_r) && cycleIdx_r == 2'h0) else $error("done end");
  chk_run_length: assert property (done_r |->
    busyCnt_r == cycles_r * OSC_PER_CYC) else $error("run length");
  chk_hold_decode: assert property (seq_run |-> $stable(opKind_r) &&
    $stable(length_r) && $stable(cycles_r)) else $error("decode moved");
  chk_first_cycle: assert property ($rose(busy_r) |->
    cycleIdx_r == 2'h1 && regSel_r == $past(opcode[2:0]) &&
    ptrSel_r == $past(opcode[0])) else $error("first cycle");
  chk_carry_only: assert property (carryWrite_r |->
    opKind_r == `LTD_OP_ROTLC || opKind_r == `LTD_OP_ROTRC)
    else $error("carry write");
  chk_shape_range: assert property (busy_r |-> length_r != 2'h0 &&
    cycles_r inside {2'h1, 2'h2}) else $error("shape");
endmodule

//--- verif/testbench.sv
// Table-driven bench for the logic and transfer decoder.
`include "ltd_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OSC = 2;
  localparam [2:0] N = `LTD_LOC_NONE, A = `LTD_LOC_ACC, G = `LTD_LOC_REG;
  localparam [2:0] D = `LTD_LOC_DIR, I = `LTD_LOC_IND, M = `LTD_LOC_IMM;
  localparam [2:0] X = `LTD_LOC_XRAM, C = `LTD_LOC_CODE;
  logic clk_sys, arst_n, oscTick, opValid, carryIn;
  logic [7:0] opcode, accIn;
  wire busy_r, done_r, handled_r, ptrSel_r, carryOut_r, carryWrite_r;
  wire passValid_r;
  wire [4:0] opKind_r;
  wire [2:0] srcLoc_r, dstLoc_r, regSel_r;
  wire [1:0] length_r, cycles_r, cycleIdx_r;
  wire [7:0] accOut_r, passOpcode_r;
  int errCount, totalChecks, i, n;
  logic [22:0] tbl[$];
  logic [7:0] o;
  logic [4:0] k;
  logic [2:0] s, d;
  logic [1:0] l, c;
  ltd_logic_transfer_decoder #(.W(8), .OSC_PER_CYC(OSC))
    ltd_logic_transfer_decoder_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .oscTick(oscTick),
    .opValid(opValid), .opcode(opcode), .accIn(accIn), .carryIn(carryIn),
    .busy_r(busy_r), .done_r(done_r), .handled_r(handled_r),
    .opKind_r(opKind_r), .srcLoc_r(srcLoc_r), .dstLoc_r(dstLoc_r),
    .length_r(length_r), .cycles_r(cycles_r), .regSel_r(regSel_r),
    .ptrSel_r(ptrSel_r), .cycleIdx_r(cycleIdx_r), .accOut_r(accOut_r),
    .carryOut_r(carryOut_r), .carryWrite_r(carryWrite_r),
    .passValid_r(passValid_r), .passOpcode_r(passOpcode_r));
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic add(input [7:0] o, input [4:0] k, input [2:0] s, d,
                     input [1:0] l, c);
    tbl.push_back({o, k, s, d, l, c});
  endtask
  // Offers one opcode and returns just after the edge that takes it.
  task automatic issue(input [7:0] op);
    @(posedge clk_sys);
    opValid <= 1'b1;
    opcode <= op;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
  endtask
  task automatic wait_done;
    for (n = 0; n < 100 && done_r !== 1'b1; n++) @(posedge clk_sys) #1;
    if (n == 100) begin
      errCount++;
      wrap_up();
    end
  endtask
  // Accumulator unit result for an input of 93 with carry clear.
  function automatic [7:0] accExp(input [4:0] kd);
    case (kd)
      `LTD_OP_ZERO: accExp = 8'h00;
      `LTD_OP_INV: accExp = 8'h6C;
      `LTD_OP_NIBSWAP: accExp = 8'h39;
      `LTD_OP_ROTL: accExp = 8'h27;
      `LTD_OP_ROTLC: accExp = 8'h26;
      `LTD_OP_ROTR: accExp = 8'hC9;
      `LTD_OP_ROTRC: accExp = 8'h49;
      default: accExp = 8'h93;
    endcase
  endfunction
  initial begin
    clk_sys = 0; arst_n = 0; oscTick = 1; opValid = 0; opcode = 8'h00;
    accIn = 8'h93; carryIn = 0; errCount = 0; totalChecks = 0;
    add(8'h58,`LTD_OP_AND,G,A,1,1); add(8'h55,`LTD_OP_AND,D,A,2,1);
    add(8'h57,`LTD_OP_AND,I,A,1,1); add(8'h54,`LTD_OP_AND,M,A,2,1);
    add(8'h52,`LTD_OP_AND,A,D,2,1); add(8'h53,`LTD_OP_AND,M,D,3,2);
    add(8'h4F,`LTD_OP_OR,G,A,1,1); add(8'h45,`LTD_OP_OR,D,A,2,1);
    add(8'h46,`LTD_OP_OR,I,A,1,1); add(8'h44,`LTD_OP_OR,M,A,2,1);
    add(8'h42,`LTD_OP_OR,A,D,2,1); add(8'h43,`LTD_OP_OR,M,D,3,2);
    add(8'h6B,`LTD_OP_XOR,G,A,1,1); add(8'h65,`LTD_OP_XOR,D,A,2,1);
    add(8'h66,`LTD_OP_XOR,I,A,1,1); add(8'h64,`LTD_OP_XOR,M,A,2,1);
    add(8'h62,`LTD_OP_XOR,A,D,2,1); add(8'h63,`LTD_OP_XOR,M,D,3,2);
    add(8'hE4,`LTD_OP_ZERO,A,A,1,1); add(8'hF4,`LTD_OP_INV,A,A,1,1);
    add(8'hC4,`LTD_OP_NIBSWAP,A,A,1,1);
    add(8'h23,`LTD_OP_ROTL,A,A,1,1);
    add(8'h33,`LTD_OP_ROTLC,A,A,1,1); add(8'h03,`LTD_OP_ROTR,A,A,1,1);
    add(8'h13,`LTD_OP_ROTRC,A,A,1,1); add(8'hE9,`LTD_OP_COPY,G,A,1,1);
    // The direct load never names the accumulator as its own source.
    add(8'hE5,`LTD_OP_COPY,D,A,2,1); add(8'hE6,`LTD_OP_COPY,I,A,1,1);
    add(8'h74,`LTD_OP_COPY,M,A,2,1); add(8'hFA,`LTD_OP_COPY,A,G,1,1);
    add(8'hAC,`LTD_OP_COPY,D,G,2,2); add(8'h7D,`LTD_OP_COPY,M,G,2,1);
    add(8'hF5,`LTD_OP_COPY,A,D,2,1); add(8'h8E,`LTD_OP_COPY,G,D,2,2);
    add(8'h85,`LTD_OP_COPY,D,D,3,2); add(8'h87,`LTD_OP_COPY,I,D,2,2);
    add(8'h75,`LTD_OP_COPY,M,D,3,2); add(8'hF7,`LTD_OP_COPY,A,I,1,1);
    add(8'hA6,`LTD_OP_COPY,D,I,2,2); add(8'h77,`LTD_OP_COPY,M,I,2,1);
    add(8'h90,`LTD_OP_DPLOAD,M,N,3,2);
    add(8'h93,`LTD_OP_CODEDP,C,A,1,2);
    add(8'h83,`LTD_OP_CODEPC,C,A,1,2);
    add(8'hE2,`LTD_OP_XRDRI,X,A,1,2);
    add(8'hE0,`LTD_OP_XRDPTR,X,A,1,2);
    add(8'hF3,`LTD_OP_XWRRI,A,X,1,2);
    add(8'hF0,`LTD_OP_XWRDPTR,A,X,1,2);
    add(8'hC0,`LTD_OP_PUSH,D,N,2,2);
    add(8'hD0,`LTD_OP_POP,N,D,2,2);
    add(8'hC8,`LTD_OP_TRADE,G,A,1,1);
    add(8'hC5,`LTD_OP_TRADE,D,A,2,1);
    add(8'hC6,`LTD_OP_TRADE,I,A,1,1);
    add(8'hD7,`LTD_OP_LOWTRADE,I,A,1,1);
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    chk("reset length", length_r, 8'h01);
    chk("reset busy", busy_r, 8'h00);
    for (i = 0; i < tbl.size(); i++) begin
      {o, k, s, d, l, c} = tbl[i];
      issue(o);
      chk("kind", opKind_r, k);
      chk("length", length_r, l);
      chk("cycles", cycles_r, c);
      chk("handled", handled_r, 8'h01);
      chk("locs", {srcLoc_r, dstLoc_r}, {s, d});
      chk("sel", {regSel_r, ptrSel_r}, {o[2:0], o[0]});
      chk("acc", accOut_r, accExp(k));
      chk("carry", {carryWrite_r, carryOut_r},
          {2{k == `LTD_OP_ROTLC || k == `LTD_OP_ROTRC}});
      wait_done();
    end
    foreach (tbl[i]) if (i < 6) begin
      o = {tbl[i][22:19] ^ 4'h7, 4'h4 ^ i[3:0]};
      issue(o);
      chk("pass", {passValid_r, handled_r, busy_r}, 8'h04);
      chk("pass op", passOpcode_r, o);
    end
    issue(8'h53);
    @(posedge clk_sys);
    opValid <= 1'b1;
    opcode <= 8'hE4;
    repeat (2) @(posedge clk_sys);
    opValid <= 1'b0;
    wait_done();
    chk("refused", opKind_r, `LTD_OP_AND);
    // Ticks held off must stall the run; carry enters the vacated bit.
    @(posedge clk_sys);
    oscTick <= 1'b0;
    accIn <= 8'h5A;
    carryIn <= 1'b1;
    issue(8'h13);
    chk("rrc acc", accOut_r, 8'hAD);
    chk("rrc carry", {carryWrite_r, carryOut_r}, 8'h02);
    repeat (5) @(posedge clk_sys);
    chk("tick hold", {busy_r, cycleIdx_r}, 8'h05);
    oscTick <= 1'b1;
    wait_done();
    issue(8'h85);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    #1;
    chk("mid reset", {busy_r, opKind_r, length_r}, 8'h01);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    issue(8'hE4);
    chk("after reset", opKind_r, `LTD_OP_ZERO);
    wait_done();
    wrap_up();
  end
endmodule
bind ltd_logic_transfer_decoder ltd_dec_properties #(.OSC_PER_CYC(OSC_PER_CYC))
  ltd_dec_properties_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .oscTick(oscTick),
  .opValid(opValid), .opcode(opcode), .busy_r(busy_r), .done_r(done_r),
  .handled_r(handled_r), .opKind_r(opKind_r), .length_r(length_r),
  .cycles_r(cycles_r), .regSel_r(regSel_r), .ptrSel_r(ptrSel_r),
  .cycleIdx_r(cycleIdx_r), .carryWrite_r(carryWrite_r),
  .passValid_r(passValid_r), .passOpcode_r(passOpcode_r));
